// file: hw/flash_host.sv
// Our own choices: strobed register access and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module flash_host
	import flash_host_pkg::*;
#(
	parameter logic [flash_host_pkg::ADDR_W-1:0] UNLOCK1_ADDR = 20'h00111,
	parameter logic [flash_host_pkg::ADDR_W-1:0] UNLOCK2_ADDR = 20'h00222,
	parameter logic [7:0] UNLOCK1_DATA = 8'h3c,
	parameter logic [7:0] UNLOCK2_DATA = 8'h4b,
	parameter logic [7:0] ID_CMD_DATA = 8'h5a,
	parameter logic [7:0] RESET_CMD_DATA = 8'h6e,
	parameter int SECTORS = flash_host_pkg::NUM_SECTORS
) (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic [flash_host_pkg::REG_ADDR_W-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_we,
	input wire logic reg_re,
	output logic [31:0] reg_rdata,
	output logic [flash_host_pkg::PIN_ADDR_W-1:0] flash_a,
	output logic flash_a_lsb,
	output logic byte_mode_n,
	input wire logic [flash_host_pkg::DATA_W-1:0] dq_in,
	output logic [flash_host_pkg::DATA_W-1:0] dq_out,
	output logic dq_oe,
	output logic ce_n,
	output logic we_n,
	output logic oe_n,
	output logic raised_high_voltage_en,
	input wire logic supply_ok
);
	import flash_host_pkg::*;

	if (SECTORS < 1 || SECTORS > (1 << SECT_IDX_W)) begin : g_chk
		$error("flash_host: SECTORS out of range");
	end

	// ==========================================================
	// Helpers
	function automatic logic [PIN_ADDR_W:0] pin_addr(
		input logic [ADDR_W-1:0] a, input logic bm);
		// Byte mode: a[0] is the extra bit below bit zero
		pin_addr = bm ? a : {a[PIN_ADDR_W-1:0], 1'b0};
	endfunction

	function automatic logic [ADDR_W-1:0] id_addr(
		input logic [ADDR_W-1:0] a, input logic [7:0] low);
		id_addr = {a[ADDR_W-1:8], low};
	endfunction

	function automatic logic [1:0] seq_last(input op_t op);
		seq_last = (op == OP_ID_ENTRY) ? 2'h2 : 2'h0;
	endfunction

	// ==========================================================
	// State
	bus_state_t state_ff, nxt_state;
	op_t op_ff, nxt_op;
	logic [1:0] idx_ff, nxt_idx;
	logic [ADDR_W-1:0] addr_ff, nxt_addr;
	logic [DATA_W-1:0] wdata_ff, nxt_wdata;
	logic [DATA_W-1:0] rdata_ff, nxt_rdata;
	logic [SECTORS-1:0] pmap_ff, nxt_pmap;
	logic byte_ff, nxt_byte;
	logic byte_n_ff;
	logic hv_ff, nxt_hv;
	logic idmode_ff, nxt_idmode;
	logic refused_ff, nxt_refused;
	logic [31:0] bus_rdata_ff, nxt_bus_rdata;
	logic [PIN_ADDR_W-1:0] a_ff, nxt_a;
	logic a_lsb_ff, nxt_a_lsb;
	logic [DATA_W-1:0] dq_out_ff, nxt_dq_out;
	logic dq_oe_ff, nxt_dq_oe;
	logic ce_n_ff, nxt_ce_n;
	logic we_n_ff, nxt_we_n;
	logic oe_n_ff, nxt_oe_n;
	logic tick;
	logic busy;
	logic go;
	op_t go_op;
	logic go_ok;
	logic [PIN_ADDR_W:0] cyc_pa;
	logic [ADDR_W-1:0] cyc_addr;
	logic [DATA_W-1:0] cyc_data;
	logic [SECT_IDX_W-1:0] sect_idx;

	phase_divider #(
		.DIV(PHASE_CYC)
	) u_div (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.run(busy),
		.tick(tick)
	);

	assign busy = (state_ff != ST_IDLE);
	assign go = reg_we && (reg_addr == REG_CTRL) && reg_wdata[CTRL_GO_BIT];
	assign go_op = op_t'(reg_wdata[CTRL_OP_MSB:CTRL_OP_LSB]);
	assign sect_idx = wdata_ff[SECT_IDX_W-1:0];

	// ==========================================================
	// Whether an order may start now
	always_comb begin
		go_ok = !busy;
		case (go_op)
			OP_ARRAY_READ: go_ok = go_ok && !idmode_ff;
			OP_ID_MFR, OP_ID_DEV, OP_ID_VERIFY:
				go_ok = go_ok && idmode_ff;
			OP_UNPROTECT:
				// All sectors must already be protected, voltage held
				go_ok = go_ok && supply_ok && hv_ff && (&pmap_ff);
			default: go_ok = go_ok && supply_ok;
		endcase
	end

	// ==========================================================
	// Address and data of the current cycle
	always_comb begin
		cyc_addr = addr_ff;
		cyc_data = wdata_ff;
		case (op_ff)
			OP_ID_ENTRY: begin
				if (idx_ff == 2'h0) begin
					cyc_addr = UNLOCK1_ADDR;
					cyc_data = {8'h00, UNLOCK1_DATA};
				end else if (idx_ff == 2'h1) begin
					cyc_addr = UNLOCK2_ADDR;
					cyc_data = {8'h00, UNLOCK2_DATA};
				end else begin
					cyc_addr = UNLOCK1_ADDR;
					cyc_data = {8'h00, ID_CMD_DATA};
				end
			end
			// Any address goes with the reset command
			OP_RESET_CMD: cyc_data = {8'h00, RESET_CMD_DATA};
			OP_ID_MFR: cyc_addr = id_addr(addr_ff, ID_MFR_LOW);
			OP_ID_DEV: cyc_addr = id_addr(addr_ff,
				byte_ff ? ID_DEV_BYTE : ID_DEV_WORD);
			OP_ID_VERIFY: cyc_addr = id_addr(addr_ff,
				byte_ff ? ID_PROT_BYTE : ID_PROT_WORD);
			default: begin
				cyc_addr = addr_ff;
				cyc_data = wdata_ff;
			end
		endcase
		cyc_pa = pin_addr(cyc_addr, byte_ff);
	end

	// ==========================================================
	// Bus cycle sequencer and software registers
	always_comb begin
		nxt_state = state_ff;
		nxt_op = op_ff;
		nxt_idx = idx_ff;
		nxt_addr = addr_ff;
		nxt_wdata = wdata_ff;
		nxt_rdata = rdata_ff;
		nxt_pmap = pmap_ff;
		nxt_byte = byte_ff;
		nxt_hv = hv_ff;
		nxt_idmode = idmode_ff;
		nxt_refused = refused_ff;
		nxt_a = a_ff;
		nxt_a_lsb = a_lsb_ff;
		nxt_dq_out = dq_out_ff;
		nxt_dq_oe = dq_oe_ff;
		nxt_ce_n = ce_n_ff;
		nxt_we_n = we_n_ff;
		nxt_oe_n = oe_n_ff;
		nxt_bus_rdata = 32'h0000_0000;

		if (reg_we) begin
			case (reg_addr)
				REG_CTRL: begin
					nxt_byte = reg_wdata[CTRL_BYTE_BIT];
					// Voltage lift only between cycles
					if (!busy) begin
						nxt_hv = reg_wdata[CTRL_HV_BIT];
					end
				end
				REG_ADDR: nxt_addr = reg_wdata[ADDR_W-1:0];
				REG_WDATA: nxt_wdata = reg_wdata[DATA_W-1:0];
				REG_STATUS: begin
					if (reg_wdata[ST_REFUSED_BIT]) begin
						nxt_refused = 1'b0;
					end
				end
				REG_PMAP: nxt_pmap = reg_wdata[SECTORS-1:0];
				default: nxt_refused = nxt_refused;
			endcase
		end
		if (reg_re) begin
			case (reg_addr)
				REG_CTRL: nxt_bus_rdata[CTRL_OP_MSB:CTRL_OP_LSB] = op_ff;
				REG_ADDR: nxt_bus_rdata[ADDR_W-1:0] = addr_ff;
				REG_WDATA: nxt_bus_rdata[DATA_W-1:0] = wdata_ff;
				REG_RDATA: nxt_bus_rdata[DATA_W-1:0] = rdata_ff;
				REG_STATUS: begin
					nxt_bus_rdata[ST_BUSY_BIT] = busy;
					nxt_bus_rdata[ST_IDMODE_BIT] = idmode_ff;
					nxt_bus_rdata[ST_REFUSED_BIT] = refused_ff;
					nxt_bus_rdata[ST_SUPPLY_BIT] = supply_ok;
					nxt_bus_rdata[ST_HV_BIT] = hv_ff;
					nxt_bus_rdata[ST_BYTE_BIT] = byte_ff;
				end
				REG_PMAP: nxt_bus_rdata[SECTORS-1:0] = pmap_ff;
				default: nxt_bus_rdata = 32'h0000_0000;
			endcase
		end

		// Supply below threshold: device resets, so does our view
		if (!supply_ok) begin
			nxt_idmode = 1'b0;
		end

		case (state_ff)
			ST_IDLE: begin
				if (go && go_ok) begin
					nxt_op = go_op;
					nxt_idx = 2'h0;
					nxt_state = (go_op == OP_WRITE_CYCLE ||
						go_op == OP_RESET_CMD ||
						go_op == OP_ID_ENTRY ||
						go_op == OP_UNPROTECT) ? ST_W_ADDR : ST_R_ADDR;
				end else if (go) begin
					nxt_refused = 1'b1;
				end
			end
			ST_W_ADDR: begin
				// Select falls first so the strobe is the later edge
				nxt_a = cyc_pa[PIN_ADDR_W:1];
				nxt_a_lsb = cyc_pa[0];
				nxt_dq_out = cyc_data;
				nxt_dq_oe = 1'b1;
				nxt_oe_n = 1'b1;
				nxt_ce_n = 1'b0;
				if (tick) begin
					nxt_we_n = 1'b0;
					nxt_state = ST_W_PULSE;
				end
			end
			ST_W_PULSE: begin
				if (tick) begin
					// Strobe rises first, data still driven
					nxt_we_n = 1'b1;
					nxt_state = ST_W_RISE;
				end
			end
			ST_W_RISE: begin
				if (tick) begin
					nxt_ce_n = 1'b1;
					nxt_state = ST_W_END;
				end
			end
			ST_W_END: begin
				if (tick) begin
					nxt_dq_oe = 1'b0;
					if (!supply_ok) begin
						// Sequence cut short; device dropped it anyway
						nxt_state = ST_IDLE;
					end else if (idx_ff != seq_last(op_ff)) begin
						nxt_idx = idx_ff + 2'h1;
						nxt_state = ST_W_ADDR;
					end else begin
						nxt_state = ST_IDLE;
						if (op_ff == OP_ID_ENTRY) begin
							nxt_idmode = 1'b1;
						end
						if (op_ff == OP_RESET_CMD) begin
							nxt_idmode = 1'b0;
						end
					end
				end
			end
			ST_R_ADDR: begin
				nxt_a = cyc_pa[PIN_ADDR_W:1];
				nxt_a_lsb = cyc_pa[0];
				nxt_dq_oe = 1'b0;
				nxt_we_n = 1'b1;
				nxt_ce_n = 1'b0;
				nxt_oe_n = 1'b0;
				if (tick) begin
					nxt_state = ST_R_SAMPLE;
				end
			end
			ST_R_SAMPLE: begin
				if (tick) begin
					nxt_rdata = dq_in;
					if (op_ff != OP_ARRAY_READ) begin
						// Identification data only on the low lanes
						nxt_rdata = {8'h00, dq_in[LANE_W-1:0]};
					end
					if (op_ff == OP_ID_VERIFY &&
						int'(sect_idx) < SECTORS) begin
						if (dq_in[LANE_W-1:0] == ID_PROT_YES) begin
							nxt_pmap[sect_idx] = 1'b1;
						end else if (dq_in[LANE_W-1:0] == ID_PROT_NO) begin
							nxt_pmap[sect_idx] = 1'b0;
						end
					end
					nxt_oe_n = 1'b1;
					nxt_ce_n = 1'b1;
					nxt_state = ST_R_END;
				end
			end
			ST_R_END: begin
				if (tick) begin
					nxt_state = ST_IDLE;
				end
			end
			default: nxt_state = ST_IDLE;
		endcase
		// A refusal in the same cycle as the clear survives
		if (state_ff == ST_IDLE && go && !go_ok) begin
			nxt_refused = 1'b1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			state_ff <= ST_IDLE;
			op_ff <= OP_ARRAY_READ;
			idx_ff <= 2'h0;
			addr_ff <= '0;
			wdata_ff <= '0;
			rdata_ff <= '0;
			pmap_ff <= '0;
			byte_ff <= 1'b0;
			hv_ff <= 1'b0;
			idmode_ff <= 1'b0;
			refused_ff <= 1'b0;
			bus_rdata_ff <= 32'h0000_0000;
			a_ff <= '0;
			a_lsb_ff <= 1'b0;
			dq_out_ff <= '0;
			dq_oe_ff <= 1'b0;
			// Strobes held high so nothing is written at power-up
			ce_n_ff <= 1'b1;
			we_n_ff <= 1'b1;
			oe_n_ff <= 1'b1;
		end else begin
			state_ff <= nxt_state;
			op_ff <= nxt_op;
			idx_ff <= nxt_idx;
			addr_ff <= nxt_addr;
			wdata_ff <= nxt_wdata;
			rdata_ff <= nxt_rdata;
			pmap_ff <= nxt_pmap;
			byte_ff <= nxt_byte;
			hv_ff <= nxt_hv;
			idmode_ff <= nxt_idmode;
			refused_ff <= nxt_refused;
			bus_rdata_ff <= nxt_bus_rdata;
			a_ff <= nxt_a;
			a_lsb_ff <= nxt_a_lsb;
			dq_out_ff <= nxt_dq_out;
			dq_oe_ff <= nxt_dq_oe;
			ce_n_ff <= nxt_ce_n;
			we_n_ff <= nxt_we_n;
			oe_n_ff <= nxt_oe_n;
		end
	end

	// ==========================================================
	// Outputs, all from flip-flops
	assign reg_rdata = bus_rdata_ff;
	assign flash_a = a_ff;
	assign flash_a_lsb = a_lsb_ff;
	assign byte_mode_n = byte_n_ff;
	assign dq_out = dq_out_ff;
	assign dq_oe = dq_oe_ff;
	assign ce_n = ce_n_ff;
	assign we_n = we_n_ff;
	assign oe_n = oe_n_ff;
	assign raised_high_voltage_en = hv_ff;

	// Pin level kept in its own flop so the output is not gated logic
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			byte_n_ff <= 1'b1;
		end else begin
			byte_n_ff <= !nxt_byte;
		end
	end

endmodule

`default_nettype wire

// file: hw/flash_host_pkg.sv
package flash_host_pkg;

	// ==========================================================
	// Timing
	localparam int CLK_PERIOD_NS = 8;
	localparam int PHASE_NS = 40;
	localparam int PHASE_CYC_RAW =
		(PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PHASE_CYC = (PHASE_CYC_RAW < 1) ? 1 : PHASE_CYC_RAW;

	// ==========================================================
	// Widths
	localparam int ADDR_W = 20;
	localparam int PIN_ADDR_W = 19;
	localparam int DATA_W = 16;
	localparam int LANE_W = 8;
	localparam int REG_ADDR_W = 8;
	localparam int NUM_SECTORS = 19;
	localparam int SECT_IDX_W = 5;

	// ==========================================================
	// Register offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_ADDR = 8'h04;
	localparam logic [7:0] REG_WDATA = 8'h08;
	localparam logic [7:0] REG_RDATA = 8'h0c;
	localparam logic [7:0] REG_STATUS = 8'h10;
	localparam logic [7:0] REG_PMAP = 8'h14;

	// ==========================================================
	// Field positions
	localparam int CTRL_GO_BIT = 0;
	localparam int CTRL_OP_LSB = 1;
	localparam int CTRL_OP_MSB = 3;
	localparam int CTRL_BYTE_BIT = 4;
	localparam int CTRL_HV_BIT = 5;
	localparam int ST_BUSY_BIT = 0;
	localparam int ST_IDMODE_BIT = 1;
	localparam int ST_REFUSED_BIT = 2;
	localparam int ST_SUPPLY_BIT = 3;
	localparam int ST_HV_BIT = 4;
	localparam int ST_BYTE_BIT = 5;

	// ==========================================================
	// Identification read offsets on the low address byte, and the protection read codes
	localparam logic [7:0] ID_MFR_LOW = 8'h00;
	localparam logic [7:0] ID_DEV_WORD = 8'h01;
	localparam logic [7:0] ID_DEV_BYTE = 8'h02;
	localparam logic [7:0] ID_PROT_WORD = 8'h02;
	localparam logic [7:0] ID_PROT_BYTE = 8'h04;
	localparam logic [7:0] ID_PROT_YES = 8'h01;
	localparam logic [7:0] ID_PROT_NO = 8'h00;

	typedef enum logic [2:0] {
		OP_ARRAY_READ,
		OP_WRITE_CYCLE,
		OP_RESET_CMD,
		OP_ID_ENTRY,
		OP_ID_MFR,
		OP_ID_DEV,
		OP_ID_VERIFY,
		OP_UNPROTECT
	} op_t;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_W_ADDR,
		ST_W_PULSE,
		ST_W_RISE,
		ST_W_END,
		ST_R_ADDR,
		ST_R_SAMPLE,
		ST_R_END
	} bus_state_t;

endpackage

// file: hw/phase_divider.sv
`timescale 1ns/1ps
`default_nettype none

module phase_divider #(
	parameter int DIV = 5
) (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic run,
	output logic tick
);
	localparam int CNT_W = (DIV > 1) ? $clog2(DIV) : 1;
	localparam logic [CNT_W-1:0] LAST = CNT_W'(DIV - 1);

	logic [CNT_W-1:0] cnt_ff;
	logic [CNT_W-1:0] nxt_cnt;
	logic tick_ff;
	logic nxt_tick;

	if (DIV < 1) begin : g_chk
		$error("phase_divider: DIV must be at least one");
	end

	// ==========================================================
	// Count only while running so every phase is a full period
	always_comb begin
		nxt_cnt = '0;
		nxt_tick = 1'b0;
		if (run) begin
			if (cnt_ff == LAST) begin
				nxt_tick = 1'b1;
			end else begin
				nxt_cnt = cnt_ff + CNT_W'(1);
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			cnt_ff <= '0;
			tick_ff <= 1'b0;
		end else begin
			cnt_ff <= nxt_cnt;
			tick_ff <= nxt_tick;
		end
	end

	assign tick = tick_ff;

endmodule

`default_nettype wire

// file: test/flash_dev_model.sv
`timescale 1ns/1ps
`default_nettype none

module flash_dev_model
	import flash_host_pkg::*;
#(
	parameter logic [19:0] U1A = 20'h00111,
	parameter logic [19:0] U2A = 20'h00222,
	parameter logic [7:0] U1D = 8'h3c,
	parameter logic [7:0] U2D = 8'h4b,
	parameter logic [7:0] IDC = 8'h5a,
	parameter logic [7:0] RSTC = 8'h6e,
	parameter logic [7:0] MFR = 8'h3a,
	parameter logic [7:0] DEV = 8'h7e,
	parameter int ACC_NS = 24
) (
	input wire logic [PIN_ADDR_W-1:0] a,
	input wire logic a_lsb,
	input wire logic byte_n,
	input wire logic ce_n,
	input wire logic we_n,
	input wire logic oe_n,
	input wire logic hv,
	input wire logic supply_ok,
	input wire logic [DATA_W-1:0] dq,
	output logic [DATA_W-1:0] dq_drv,
	output logic dq_en
);
	// ==========================================================
	// Command state
	logic [1:0] mode = 2'd0;
	logic [18:0] prot = '0;
	logic [19:0] lat_a = '0;
	logic wr_on = 1'b0;
	logic [15:0] last = '0;
	wire [19:0] fa = byte_n ? {1'b0, a} : {a, a_lsb};
	wire rd = !ce_n && !oe_n && we_n;

	always @(negedge ce_n or negedge we_n) begin
		if (!ce_n && !we_n && oe_n && supply_ok) begin
			lat_a = fa;
			wr_on = 1'b1;
		end
	end

	always @(posedge ce_n or posedge we_n or negedge supply_ok) begin
		if (!supply_ok) begin
			mode = 2'd0;
			wr_on = 1'b0;
		end else if (wr_on) begin
			wr_on = 1'b0;
			// Reset aborts any sequence between its cycles
			if (dq[7:0] == RSTC) begin
				mode = 2'd0;
			end else begin
				case (mode)
				2'd0: mode = (lat_a == U1A && dq[7:0] == U1D) ? 2'd1 : 2'd0;
				2'd1: mode = (lat_a == U2A && dq[7:0] == U2D) ? 2'd2 : 2'd0;
				2'd2: mode = (lat_a == U1A && dq[7:0] == IDC) ? 2'd3 : 2'd0;
				default: mode = 2'd3;
				endcase
			end
		end
	end

	// Only the low lanes carry codes; protection is lifted by raised voltage
	function automatic logic [15:0] val(input logic [1:0] m,
		input logic [19:0] x, input logic bn, input logic h);
		if (m != 2'd3)
			// No erase pause modelled, so no address reads status
			return x[15:0] ^ 16'ha5c3;
		if (x[7:0] == 8'h00)
			return {8'h00, MFR};
		if (x[7:0] == (bn ? 8'h01 : 8'h02))
			return {8'h00, DEV};
		if (x[7:0] == (bn ? 8'h02 : 8'h04))
			return {15'h0, |(prot & {19{~h}})};
		return 16'h0;
	endfunction

	// Released bus shows the inverse so no stale value passes for data
	always @(posedge oe_n) last = dq_drv;
	assign #ACC_NS dq_en = rd;
	assign #ACC_NS dq_drv = rd ? val(mode, fa, byte_n, hv) : ~last;
endmodule

`default_nettype wire

// file: test/flash_host_bench.sv
`timescale 1ns/1ps
`default_nettype none

`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin num_errors++; \
	$display("ERROR %0t: mismatch got %h exp %h", $time, g, e); end end

module flash_host_bench;
	import flash_host_pkg::*;
	localparam logic [19:0] U1A = 20'h00111;
	localparam logic [19:0] U2A = 20'h00222;
	localparam logic [7:0] U1D = 8'h3c;
	localparam logic [7:0] U2D = 8'h4b;
	localparam logic [7:0] IDC = 8'h5a;
	localparam logic [7:0] RSTC = 8'h6e;
	localparam logic [7:0] MFR = 8'h3a; // Arbitrary code
	localparam logic [7:0] DEV = 8'h7e; // Arbitrary code
	localparam logic [15:0] PAT = 16'ha5c3;
	logic ref_clk, rstn, reg_we, reg_re, supply_ok, bm, hv;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, d, r;
	logic [18:0] fa;
	logic fa_lsb, byte_n, dq_oe, ce_n, we_n, oe_n, hv_en, dev_en;
	logic [15:0] dq_in, dq_out, dev_dq;
	int num_errors = 0;
	int comparisons = 0;

	// ==========================================================
	// Harness
	always #4 ref_clk = ~ref_clk;
	assign dq_in = dq_oe ? dq_out : dev_dq;

	flash_host #(.UNLOCK1_ADDR(U1A), .UNLOCK2_ADDR(U2A), .UNLOCK1_DATA(U1D),
		.UNLOCK2_DATA(U2D), .ID_CMD_DATA(IDC), .RESET_CMD_DATA(RSTC)
	) u_flash_host (.ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
		.reg_rdata(reg_rdata), .flash_a(fa), .flash_a_lsb(fa_lsb),
		.byte_mode_n(byte_n), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
		.ce_n(ce_n), .we_n(we_n), .oe_n(oe_n),
		.raised_high_voltage_en(hv_en), .supply_ok(supply_ok));

	flash_dev_model #(.U1A(U1A), .U2A(U2A), .U1D(U1D), .U2D(U2D), .IDC(IDC),
		.RSTC(RSTC), .MFR(MFR), .DEV(DEV)
	) u_dev (.a(fa), .a_lsb(fa_lsb), .byte_n(byte_n), .ce_n(ce_n),
		.we_n(we_n), .oe_n(oe_n), .hv(hv_en), .supply_ok(supply_ok),
		.dq(dq_in), .dq_drv(dev_dq), .dq_en(dev_en));

	task automatic conclude();
		if (num_errors == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_we <= 1'b1;
		@(posedge ref_clk);
		reg_we <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_re <= 1'b1;
		@(posedge ref_clk);
		reg_re <= 1'b0;
		@(negedge ref_clk);
		v = reg_rdata;
	endtask

	// Busy polling is bounded so a stuck sequencer ends the run
	task automatic go(input op_t op);
		int i;
		logic [31:0] s;
		wr(REG_CTRL, {26'h0, hv, bm, op, 1'b1});
		for (i = 0; i < 400; i++) begin
			rd(REG_STATUS, s);
			if (s[ST_BUSY_BIT] === 1'b0)
				break;
		end
		if (i == 400) begin
			num_errors++;
			$display("ERROR %0t: busy timeout", $time);
			conclude();
		end
	endtask

	task automatic wcyc(input logic [19:0] a, input logic [7:0] v);
		wr(REG_ADDR, {12'h0, a});
		wr(REG_WDATA, {24'h0, v});
		go(OP_WRITE_CYCLE);
	endtask

	// ==========================================================
	// Scenarios
	initial begin
		ref_clk = 0; rstn = 0; reg_addr = '0; reg_wdata = '0;
		reg_we = 0; reg_re = 0; supply_ok = 1; bm = 0; hv = 0;
		void'($urandom(32'h9071));
		repeat (12) @(posedge ref_clk);
		rstn <= 1'b1;
		rd(REG_STATUS, d); `CHK(d[5:0], 6'b001000)
		rd(REG_PMAP, d); `CHK(d[18:0], 19'h0)
		rd(8'h20, d); `CHK(d, 32'h0)
		go(OP_ID_ENTRY);
		rd(REG_STATUS, d); `CHK(d[ST_IDMODE_BIT], 1'b1)
		`CHK(u_dev.mode, 2'd3)
		repeat (2) begin
			r = $urandom;
			wr(REG_ADDR, {12'h0, r[19:8], 8'h00});
			go(OP_ID_MFR);
			rd(REG_RDATA, d); `CHK(d[15:0], {8'h00, MFR})
		end
		go(OP_ID_DEV);
		rd(REG_RDATA, d); `CHK(d[7:0], DEV)
		bm = 1;
		wr(REG_CTRL, {26'h0, hv, bm, 4'h0});
		go(OP_ID_DEV);
		`CHK(byte_n, 1'b0)
		rd(REG_RDATA, d); `CHK(d[7:0], DEV)
		wr(REG_PMAP, 32'h7ffff);
		wr(REG_WDATA, 32'h5);
		go(OP_ID_VERIFY);
		rd(REG_RDATA, d); `CHK(d[7:0], ID_PROT_NO)
		rd(REG_PMAP, d); `CHK(d[18:0], 19'h7ffdf)
		bm = 0;
		go(OP_ARRAY_READ);
		rd(REG_STATUS, d); `CHK(d[ST_REFUSED_BIT], 1'b1)
		wr(REG_STATUS, 32'h4);
		go(OP_UNPROTECT);
		rd(REG_STATUS, d); `CHK(d[2:1], 2'b11)
		wr(REG_STATUS, 32'h4);
		r = $urandom;
		wr(REG_ADDR, {12'h0, r[19:0]});
		go(OP_RESET_CMD);
		rd(REG_STATUS, d); `CHK(d[2:1], 2'b00)
		`CHK(u_dev.mode, 2'd0)
		repeat (3) begin
			r = $urandom & 32'h7ffff;
			wr(REG_ADDR, r);
			go(OP_ARRAY_READ);
			rd(REG_RDATA, d); `CHK(d[15:0], r[15:0] ^ PAT)
		end
		wcyc(U1A, U1D); `CHK(u_dev.mode, 2'd1)
		wcyc(U1A, 8'h00); `CHK(u_dev.mode, 2'd0)
		wcyc(U1A, U1D);
		wcyc(U2A, U2D); `CHK(u_dev.mode, 2'd2)
		go(OP_RESET_CMD); `CHK(u_dev.mode, 2'd0)
		@(posedge ref_clk);
		supply_ok <= 1'b0;
		rd(REG_STATUS, d); `CHK(d[ST_SUPPLY_BIT], 1'b0)
		go(OP_ID_ENTRY);
		rd(REG_STATUS, d); `CHK(d[2:1], 2'b10)
		`CHK(u_dev.mode, 2'd0)
		wr(REG_STATUS, 32'h4);
		supply_ok <= 1'b1;
		hv = 1;
		wr(REG_CTRL, {26'h0, hv, bm, 4'h0});
		repeat (3) @(posedge ref_clk);
		`CHK(hv_en, 1'b1)
		rd(REG_STATUS, d); `CHK(d[ST_HV_BIT], 1'b1)
		// One sector still unprotected: unprotect must wait
		go(OP_UNPROTECT);
		rd(REG_STATUS, d); `CHK(d[ST_REFUSED_BIT], 1'b1)
		wr(REG_STATUS, 32'h4);
		wr(REG_PMAP, 32'h7ffff);
		go(OP_UNPROTECT);
		rd(REG_STATUS, d); `CHK(d[2:0], 3'h0)
		conclude();
	end
endmodule

`default_nettype wire

// file: test/flash_host_checker.sv
`timescale 1ns/1ps
`default_nettype none

module flash_host_checker
	import flash_host_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic [flash_host_pkg::PIN_ADDR_W-1:0] flash_a,
	input wire logic flash_a_lsb,
	input wire logic [flash_host_pkg::DATA_W-1:0] dq_out,
	input wire logic dq_oe,
	input wire logic ce_n,
	input wire logic we_n,
	input wire logic oe_n,
	input wire logic raised_high_voltage_en,
	input wire logic supply_ok
);
	// ==========================================================
	// Pin protocol
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rstn);

	a_reset_idle: assert property (
		$rose(rstn) |-> ce_n && we_n && oe_n && !dq_oe)
		else $error("pins not idle after reset");
	a_write_levels: assert property (
		!we_n |-> !ce_n && oe_n && dq_oe)
		else $error("write strobe without select or with output drive");
	a_read_levels: assert property (
		!oe_n |-> !ce_n && we_n && !dq_oe)
		else $error("read with write strobe or host driving");
	a_select_first: assert property (
		$fell(we_n) |-> !$past(ce_n))
		else $error("strobe fell before select");
	a_addr_hold: assert property (
		!we_n |-> $stable(flash_a) && $stable(flash_a_lsb))
		else $error("address moved in write pulse");
	a_data_first: assert property (
		$rose(we_n) |-> !ce_n && dq_oe && $stable(dq_out))
		else $error("data not held at strobe rise");
	a_select_after: assert property (
		$rose(ce_n) |-> we_n && $past(we_n))
		else $error("select rose before strobe");
	a_pulse_width: assert property (
		$fell(we_n) |-> (!we_n)[*5] ##1 we_n)
		else $error("write pulse not one phase");
	a_lockout_write: assert property (
		$fell(we_n) |-> supply_ok)
		else $error("write below supply threshold");

	cover property ($fell(we_n));
	cover property ($fell(oe_n));
	cover property ($rose(raised_high_voltage_en));
endmodule

bind flash_host flash_host_checker u_flash_host_checker (
	.ref_clk(ref_clk), .rstn(rstn), .flash_a(flash_a),
	.flash_a_lsb(flash_a_lsb), .dq_out(dq_out), .dq_oe(dq_oe),
	.ce_n(ce_n), .we_n(we_n), .oe_n(oe_n),
	.raised_high_voltage_en(raised_high_voltage_en), .supply_ok(supply_ok)
);

`default_nettype wire
